// ==== rtl/agpsb_target.sv ====
// Target side of a graphics port: request queueing, sideband capture,
// read flow control, grant/status and strobed data halves.
// Assumes master pins are asynchronous to clock and filtered here.
`timescale 1ns/100ps
module agpsb_target (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic pipelined_req_n,
    input wire logic graphics_req_n,
    input wire logic read_buffer_full_n,
    input wire logic [agpsb_pkg::AGPSB_SB_W-1:0] sideband_addr,
    input wire logic sideband_strobe,
    input wire logic [agpsb_pkg::AGPSB_AD_W-1:0] graphics_addr_data_i,
    output logic [agpsb_pkg::AGPSB_AD_W-1:0] graphics_addr_data_o,
    output logic graphics_addr_data_oe,
    input wire logic low_half_data_strobe_i,
    output logic low_half_data_strobe_o,
    output logic low_half_data_strobe_oe,
    input wire logic high_half_data_strobe_i,
    output logic high_half_data_strobe_o,
    output logic high_half_data_strobe_oe,
    output logic graphics_grant_n,
    output logic [agpsb_pkg::AGPSB_ST_W-1:0] grant_status,
    output logic req_valid,
    input wire logic req_ready,
    output logic [agpsb_pkg::AGPSB_AD_W-1:0] req_data,
    output logic req_overflow,
    output logic sb_valid,
    output logic [agpsb_pkg::AGPSB_SB_W-1:0] sb_data,
    output logic wr_valid,
    output logic [agpsb_pkg::AGPSB_AD_W-1:0] wr_data,
    input wire logic rd_valid,
    input wire logic rd_high,
    input wire logic [agpsb_pkg::AGPSB_AD_W-1:0] rd_data,
    output logic rd_taken
);
    import agpsb_pkg::*;

    // ************************************************************
    // Pin sampling: three stages, change accepted when 2 and 3 agree
    // ************************************************************
    logic [AGPSB_IN_W-1:0] pins;
    logic [AGPSB_IN_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    logic [AGPSB_IN_W-1:0] s1_d, s2_d, s3_d;

    assign pins = {pipelined_req_n, read_buffer_full_n, graphics_req_n, sideband_strobe,
                   low_half_data_strobe_i, high_half_data_strobe_i, sideband_addr, graphics_addr_data_i};

    genvar gi;
    generate
        for (gi = 0; gi < AGPSB_IN_W; gi++) begin : g_filt
            assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
        end
    endgenerate

    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= AGPSB_RST_PINS;
            s2_q <= AGPSB_RST_PINS;
            s3_q <= AGPSB_RST_PINS;
            filt_q <= AGPSB_RST_PINS;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            filt_q <= filt_d;
        end
    end

    logic pipe_act, rbf_clear, req_act;
    logic [AGPSB_AD_W-1:0] ad_in;
    logic [AGPSB_SB_W-1:0] sb_in;
    assign pipe_act = !filt_q[AGPSB_IN_PIPE];
    assign rbf_clear = filt_q[AGPSB_IN_RBF];
    assign req_act = !filt_q[AGPSB_IN_REQ];
    assign ad_in = filt_q[AGPSB_IN_AD_LSB +: AGPSB_AD_W];
    assign sb_in = filt_q[AGPSB_IN_SB_LSB +: AGPSB_SB_W];

    // ************************************************************
    // Request queue
    // ************************************************************
    logic fifo_in_ready;
    logic [AGPSB_LVL_W-1:0] level;
    logic ovf_q, ovf_d;

    agpsb_fifo #(
        .WIDTH(AGPSB_AD_W),
        .DEPTH(AGPSB_FIFO_DEPTH)
    ) u_queue (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(pipe_act),
        .in_ready(fifo_in_ready),
        .in_data(ad_in),
        .out_valid(req_valid),
        .out_ready(req_ready),
        .out_data(req_data),
        .level(level)
    );

    always_comb begin
        ovf_d = ovf_q || (pipe_act && !fifo_in_ready);
    end

    // ************************************************************
    // Sideband and strobed write halves
    // ************************************************************
    logic sb_prev_q, lo_prev_q, hi_prev_q, sb_edge, lo_edge, hi_edge;
    logic sb_valid_q, sb_valid_d, wr_valid_q, wr_valid_d, lo_got_q, lo_got_d, hi_got_q, hi_got_d;
    logic [AGPSB_SB_W-1:0] sb_q, sb_d;
    logic [AGPSB_HALF_W-1:0] lo_q, lo_d, hi_q, hi_d;
    logic [AGPSB_AD_W-1:0] wr_q, wr_d;
    logic drive_q;

    always_comb begin
        sb_edge = filt_q[AGPSB_IN_SB_STB] && !sb_prev_q;
        lo_edge = filt_q[AGPSB_IN_LO_STB] && !lo_prev_q && !drive_q;
        hi_edge = filt_q[AGPSB_IN_HI_STB] && !hi_prev_q && !drive_q;
        sb_valid_d = sb_edge;
        sb_d = sb_edge ? sb_in : sb_q;
        lo_d = lo_edge ? ad_in[AGPSB_HALF_W-1:0] : lo_q;
        hi_d = hi_edge ? ad_in[AGPSB_AD_W-1:AGPSB_HALF_W] : hi_q;
        lo_got_d = lo_got_q || lo_edge;
        hi_got_d = hi_got_q || hi_edge;
        wr_valid_d = 1'b0;
        wr_d = wr_q;
        if (lo_got_d && hi_got_d) begin
            wr_valid_d = 1'b1;
            wr_d = {hi_d, lo_d};
            lo_got_d = 1'b0;
            hi_got_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sb_prev_q <= 1'b0;
            lo_prev_q <= 1'b0;
            hi_prev_q <= 1'b0;
            sb_valid_q <= 1'b0;
            sb_q <= '0;
            lo_q <= '0;
            hi_q <= '0;
            lo_got_q <= 1'b0;
            hi_got_q <= 1'b0;
            wr_valid_q <= 1'b0;
            wr_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            sb_prev_q <= filt_q[AGPSB_IN_SB_STB];
            lo_prev_q <= filt_q[AGPSB_IN_LO_STB];
            hi_prev_q <= filt_q[AGPSB_IN_HI_STB];
            sb_valid_q <= sb_valid_d;
            sb_q <= sb_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
            lo_got_q <= lo_got_d;
            hi_got_q <= hi_got_d;
            wr_valid_q <= wr_valid_d;
            wr_q <= wr_d;
            ovf_q <= ovf_d;
        end
    end

    // ************************************************************
    // Grant, status and read return
    // ************************************************************
    agpsb_state_e state_q, state_d;
    logic gnt_n_q, gnt_n_d, oe_q, oe_d, stb_q, stb_d, taken_q, taken_d;
    logic [3:0] hist_q, hist_d;
    logic [AGPSB_ST_W-1:0] st_q, st_d;
    logic [AGPSB_AD_W-1:0] dout_q, dout_d;
    logic rd_ok, room;

    always_comb begin
        rd_ok = rd_valid && (rd_high || rbf_clear);
        room = level < AGPSB_ROOM_LIMIT;
        state_d = state_q;
        gnt_n_d = 1'b1;
        st_d = AGPSB_ST_START;
        oe_d = 1'b0;
        stb_d = 1'b0;
        taken_d = 1'b0;
        dout_d = dout_q;
        hist_d = {hist_q[2:0], oe_q};
        case (state_q)
            AGPSB_S_IDLE: begin
                if (rd_ok) begin
                    gnt_n_d = 1'b0;
                    st_d = rd_high ? AGPSB_ST_RD_HIGH : AGPSB_ST_RD_LOW;
                    dout_d = rd_data;
                    taken_d = 1'b1;
                    state_d = AGPSB_S_GRANT;
                end else if (req_act && room) begin
                    gnt_n_d = 1'b0;
                end
            end
            AGPSB_S_GRANT: begin
                oe_d = 1'b1;
                stb_d = 1'b1;
                state_d = AGPSB_S_DRIVE;
            end
            AGPSB_S_DRIVE: begin
                oe_d = 1'b1;
                state_d = AGPSB_S_END;
            end
            AGPSB_S_END: begin
                state_d = AGPSB_S_IDLE;
            end
            default: begin
                state_d = AGPSB_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= AGPSB_S_IDLE;
            gnt_n_q <= AGPSB_RST_GRANT_N;
            st_q <= AGPSB_ST_START;
            oe_q <= 1'b0;
            stb_q <= 1'b0;
            taken_q <= 1'b0;
            dout_q <= '0;
            hist_q <= 4'h0;
        end else begin
            state_q <= state_d;
            gnt_n_q <= gnt_n_d;
            st_q <= st_d;
            oe_q <= oe_d;
            stb_q <= stb_d;
            taken_q <= taken_d;
            dout_q <= dout_d;
            hist_q <= hist_d;
        end
    end

    // Own strobes reach the filter late; ignore edges for a while after driving
    assign drive_q = oe_q || (hist_q != 4'h0);
    assign graphics_grant_n = gnt_n_q;
    assign grant_status = st_q;
    assign graphics_addr_data_o = dout_q;
    assign graphics_addr_data_oe = oe_q;
    assign low_half_data_strobe_o = stb_q;
    assign low_half_data_strobe_oe = oe_q;
    assign high_half_data_strobe_o = stb_q;
    assign high_half_data_strobe_oe = oe_q;
    assign rd_taken = taken_q;
    assign req_overflow = ovf_q;
    assign sb_valid = sb_valid_q;
    assign sb_data = sb_q;
    assign wr_valid = wr_valid_q;
    assign wr_data = wr_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    queue_push_a: assert property (pipe_act && fifo_in_ready && !(req_valid && req_ready) |=>
        level == AGPSB_LVL_W'($past(level) + 1'b1)) else $error("request not queued");
    queue_idle_a: assert property (!pipe_act |=> level <= $past(level))
        else $error("queued without pipelined request");
    sideband_take_a: assert property (sb_edge |=> sb_valid && sb_data == $past(sb_in))
        else $error("sideband byte lost");
    rbf_hold_a: assert property (!rbf_clear && !rd_high |=>
        !(!graphics_grant_n && grant_status == AGPSB_ST_RD_LOW)) else $error("low read while buffer full");
    low_half_a: assert property (lo_edge |=> lo_q == $past(ad_in[AGPSB_HALF_W-1:0]))
        else $error("low half not captured");
    high_half_a: assert property (hi_edge |=> hi_q == $past(ad_in[AGPSB_AD_W-1:AGPSB_HALF_W]))
        else $error("high half not captured");
    strobe_drive_a: assert property (state_q == AGPSB_S_GRANT |=>
        low_half_data_strobe_oe && high_half_data_strobe_o ##1 graphics_addr_data_oe ##1 !high_half_data_strobe_oe)
        else $error("strobe drive window wrong");
    grant_pulse_a: assert property (!graphics_grant_n && grant_status != AGPSB_ST_START |=> graphics_grant_n)
        else $error("read grant longer than one cycle");
    room_grant_a: assert property (!graphics_grant_n && grant_status == AGPSB_ST_START |->
        $past(level) < AGPSB_ROOM_LIMIT) else $error("start grant with queue near full");

    read_return_c: cover property (rd_taken ##1 graphics_addr_data_oe ##2 !graphics_addr_data_oe);
    start_grant_c: cover property (!graphics_grant_n && grant_status == AGPSB_ST_START);
    write_word_c: cover property (wr_valid);
    pipe_burst_c: cover property (pipe_act [*4]);

endmodule

// ==== rtl/agpsb_pkg.sv ====
// Constants, codes and state encoding for the graphics port request target.
// Assumes a single 25 MHz clock; all pins are sampled into that domain.
package agpsb_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int AGPSB_AD_W = 32;
    localparam int AGPSB_HALF_W = 16;
    localparam int AGPSB_SB_W = 8;
    localparam int AGPSB_ST_W = 3;
    localparam int AGPSB_FIFO_DEPTH = 8;
    localparam int AGPSB_LVL_W = 4;

    // ************************************************************
    // Positions in the sampled pin vector
    // ************************************************************
    localparam int AGPSB_IN_AD_LSB = 0;
    localparam int AGPSB_IN_SB_LSB = 32;
    localparam int AGPSB_IN_HI_STB = 40;
    localparam int AGPSB_IN_LO_STB = 41;
    localparam int AGPSB_IN_SB_STB = 42;
    localparam int AGPSB_IN_REQ = 43;
    localparam int AGPSB_IN_RBF = 44;
    localparam int AGPSB_IN_PIPE = 45;
    localparam int AGPSB_IN_W = 46;

    // ************************************************************
    // Status codes and reset values
    // ************************************************************
    localparam logic [2:0] AGPSB_ST_RD_LOW = 3'h0;
    localparam logic [2:0] AGPSB_ST_RD_HIGH = 3'h1;
    localparam logic [2:0] AGPSB_ST_START = 3'h7;
    localparam logic AGPSB_RST_GRANT_N = 1'h1;
    localparam logic [45:0] AGPSB_RST_PINS = 46'h38_0000_0000_00;

    // Start grants only while the queue holds fewer than this many
    localparam logic [3:0] AGPSB_ROOM_LIMIT = 4'h4;

    typedef enum logic [1:0] {
        AGPSB_S_IDLE = 2'h0,
        AGPSB_S_GRANT = 2'h1,
        AGPSB_S_DRIVE = 2'h3,
        AGPSB_S_END = 2'h2
    } agpsb_state_e;

endpackage

// ==== rtl/agpsb_fifo.sv ====
// Request queue: synchronous FIFO with valid/ready on both sides.
// Assumes one clock; level reports the number of stored words.
`timescale 1ns/100ps
module agpsb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    logic valid_q, valid_d;

    // ************************************************************
    // Pointers and count
    // ************************************************************
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW + 1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW + 1)'(cnt_q - 1'b1);
        end
        valid_d = (cnt_d != '0);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            valid_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
        end
    end

    // ************************************************************
    // Storage
    // ************************************************************
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = valid_q;
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;

endmodule

// ==== verif/agpsb_master_model.sv ====
// Graphics master model: drives the port pins of the request target.
// Assumes the bench calls its tasks; shared wires are resolved here from both enables.
`timescale 1ns/100ps
module agpsb_master_model (
    input wire logic clock,
    input wire logic [agpsb_pkg::AGPSB_AD_W-1:0] tgt_ad,
    input wire logic tgt_ad_oe,
    input wire logic tgt_lo,
    input wire logic tgt_lo_oe,
    input wire logic tgt_hi,
    input wire logic tgt_hi_oe,
    output logic pipelined_req_n,
    output logic graphics_req_n,
    output logic read_buffer_full_n,
    output logic [agpsb_pkg::AGPSB_SB_W-1:0] sideband_addr,
    output logic sideband_strobe,
    output logic [agpsb_pkg::AGPSB_AD_W-1:0] ad_wire,
    output logic lo_wire,
    output logic hi_wire
);
    import agpsb_pkg::*;
    logic [AGPSB_AD_W-1:0] ad_q, noise_q;
    logic ad_oe_q, stb_oe_q, lo_q, hi_q;
    initial begin
        pipelined_req_n = 1'b1;
        graphics_req_n = 1'b1;
        read_buffer_full_n = 1'b1;
        sideband_addr = 8'h00;
        sideband_strobe = 1'b0;
        ad_q = 32'h0000_0000;
        noise_q = 32'h0000_0000;
        {ad_oe_q, stb_oe_q, lo_q, hi_q} = 4'h0;
    end
    // Released lines show a pattern that changes every cycle
    always @(posedge clock) noise_q <= ~noise_q;
    assign ad_wire = tgt_ad_oe ? tgt_ad : (ad_oe_q ? ad_q : noise_q);
    assign lo_wire = tgt_lo_oe ? tgt_lo : (stb_oe_q ? lo_q : noise_q[0]);
    assign hi_wire = tgt_hi_oe ? tgt_hi : (stb_oe_q ? hi_q : noise_q[1]);
    task automatic set_pins(input logic req_n, input logic full_n);
        @(posedge clock);
        graphics_req_n <= req_n;
        read_buffer_full_n <= full_n;
    endtask
    task automatic pipe_burst(input logic [31:0] d, input int n);
        @(posedge clock);
        ad_oe_q <= 1'b1;
        ad_q <= d;
        pipelined_req_n <= 1'b0;
        repeat (n) @(posedge clock);
        pipelined_req_n <= 1'b1;
        repeat (5) @(posedge clock);
        ad_oe_q <= 1'b0;
    endtask
    task automatic sb_byte(input logic [7:0] b);
        @(posedge clock);
        sideband_addr <= b;
        repeat (4) @(posedge clock);
        sideband_strobe <= 1'b1;
        repeat (4) @(posedge clock);
        sideband_strobe <= 1'b0;
    endtask
    task automatic wr_pulse(input logic lo, input logic hi, input logic [31:0] d);
        @(posedge clock);
        {ad_oe_q, stb_oe_q, lo_q, hi_q} <= 4'hc;
        ad_q <= d;
        repeat (4) @(posedge clock);
        lo_q <= lo;
        hi_q <= hi;
        repeat (4) @(posedge clock);
        {lo_q, hi_q} <= 2'h0;
        repeat (4) @(posedge clock);
        {ad_oe_q, stb_oe_q} <= 2'h0;
    endtask
endmodule

// ==== verif/test_agp_sideband_request_flow.sv ====
// Testbench of the graphics port request target with a master model.
// Assumes a 25 MHz clock; results are compared against queued notes.
`timescale 1ns/100ps
module test_agp_sideband_request_flow;
    import agpsb_pkg::*;
    logic clock, arst_n, req_ready, rd_valid, rd_high, rd_taken;
    logic [31:0] rd_data, ad_o, ad_wire, req_data, wr_data, d, d2;
    logic ad_oe, lo_o, lo_oe, hi_o, hi_oe, lo_wire, hi_wire, graphics_grant_n;
    logic pipelined_req_n, graphics_req_n, read_buffer_full_n, sideband_strobe;
    logic req_valid, req_overflow, sb_valid, wr_valid;
    logic [7:0] sideband_addr, sb_data;
    logic [2:0] grant_status;
    logic [31:0] q_req[$], q_wr[$];
    logic [7:0] q_sb[$];
    int fails, num_checks, cycles, n, seed;
    // ************************************************************
    // Clock, partner and design
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    agpsb_master_model u_agpsb_master_model (.clock, .tgt_ad(ad_o), .tgt_ad_oe(ad_oe),
        .tgt_lo(lo_o), .tgt_lo_oe(lo_oe), .tgt_hi(hi_o), .tgt_hi_oe(hi_oe), .pipelined_req_n,
        .graphics_req_n, .read_buffer_full_n, .sideband_addr, .sideband_strobe, .ad_wire,
        .lo_wire, .hi_wire);
    agpsb_target u_agpsb_target (.clock, .arst_n, .pipelined_req_n, .graphics_req_n,
        .read_buffer_full_n, .sideband_addr, .sideband_strobe, .graphics_addr_data_i(ad_wire),
        .graphics_addr_data_o(ad_o), .graphics_addr_data_oe(ad_oe),
        .low_half_data_strobe_i(lo_wire), .low_half_data_strobe_o(lo_o), .low_half_data_strobe_oe(lo_oe),
        .high_half_data_strobe_i(hi_wire), .high_half_data_strobe_o(hi_o),
        .high_half_data_strobe_oe(hi_oe), .graphics_grant_n, .grant_status, .req_valid, .req_ready,
        .req_data, .req_overflow, .sb_valid, .sb_data, .wr_valid, .wr_data, .rd_valid, .rd_high,
        .rd_data, .rd_taken);
    // ************************************************************
    // Checking
    // ************************************************************
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            $display("unexpected at %0t: %s", $time, msg);
            fails++;
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    always @(negedge clock) begin
        if (req_valid === 1'b1 && req_ready === 1'b1) begin
            if (q_req.size() == 0) check(1'b0, "queued word without note");
            else check(req_data === q_req.pop_front(), "queued word");
        end
        if (sb_valid === 1'b1) begin
            if (q_sb.size() == 0) check(1'b0, "sideband byte without note");
            else check(sb_data === q_sb.pop_front(), "sideband byte");
        end
        if (wr_valid === 1'b1) begin
            if (q_wr.size() == 0) check(1'b0, "write word without note");
            else check(wr_data === q_wr.pop_front(), "write word");
        end
        if (u_agpsb_master_model.stb_oe_q === 1'b1) check(lo_oe === 1'b0 && hi_oe === 1'b0, "strobe clash");
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic rd_word(input logic high, input logic [2:0] st);
        logic [31:0] w;
        w = $urandom;
        n = 0;
        @(posedge clock);
        rd_valid <= 1'b1;
        rd_high <= high;
        rd_data <= w;
        if (!high) begin
            repeat (20) begin
                @(negedge clock);
                check(rd_taken !== 1'b1, "low read while buffer full");
            end
            u_agpsb_master_model.set_pins(1'b1, 1'b1);
        end
        @(negedge clock);
        while (rd_taken !== 1'b1 && n < 16) begin
            @(negedge clock);
            n++;
        end
        check(rd_taken === 1'b1 && graphics_grant_n === 1'b0 && grant_status === st, "read grant");
        @(posedge clock);
        rd_valid <= 1'b0;
        @(negedge clock);
        check(ad_oe === 1'b1 && ad_o === w && {lo_oe, hi_oe, lo_o, hi_o} === 4'hf, "read drive");
    endtask
    initial begin
        {arst_n, req_ready, rd_valid, rd_high} = 4'h4;
        rd_data = 32'h0000_0000;
        {fails, num_checks, cycles} = 0;
        seed = $urandom(73497);
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
        d = $urandom;
        repeat (3) q_req.push_back(d);
        u_agpsb_master_model.pipe_burst(d, 3);
        repeat (10) @(posedge clock);
        check(q_req.size() == 0 && req_overflow === 1'b0, "burst drained");
        req_ready <= 1'b0;
        d = $urandom;
        repeat (8) q_req.push_back(d);
        u_agpsb_master_model.pipe_burst(d, 10);
        u_agpsb_master_model.set_pins(1'b0, 1'b1);
        repeat (12) begin
            @(negedge clock);
            check(graphics_grant_n === 1'b1, "start grant while queue full");
        end
        check(req_overflow === 1'b1, "overflow flag");
        @(posedge clock);
        req_ready <= 1'b1;
        n = 0;
        @(negedge clock);
        while (graphics_grant_n !== 1'b0 && n < 20) begin
            @(negedge clock);
            n++;
        end
        check(graphics_grant_n === 1'b0 && grant_status === AGPSB_ST_START, "start grant");
        repeat (4) @(negedge clock);
        check(q_req.size() == 0, "queue drained");
        u_agpsb_master_model.set_pins(1'b1, 1'b1);
        repeat (4) begin
            q_sb.push_back(8'($urandom));
            u_agpsb_master_model.sb_byte(q_sb[$]);
        end
        d = $urandom;
        d2 = $urandom;
        q_wr.push_back({d2[31:16], d[15:0]});
        u_agpsb_master_model.wr_pulse(1'b1, 1'b0, d);
        u_agpsb_master_model.wr_pulse(1'b0, 1'b1, d2);
        d = $urandom;
        q_wr.push_back(d);
        u_agpsb_master_model.wr_pulse(1'b1, 1'b1, d);
        u_agpsb_master_model.set_pins(1'b1, 1'b0);
        repeat (6) @(posedge clock);
        rd_word(1'b1, AGPSB_ST_RD_HIGH);
        u_agpsb_master_model.set_pins(1'b1, 1'b0);
        repeat (6) @(posedge clock);
        rd_word(1'b0, AGPSB_ST_RD_LOW);
        repeat (10) @(posedge clock);
        check(q_req.size() + q_sb.size() + q_wr.size() == 0, "notes left over");
        finish_test();
    end
endmodule
